// File: logic/iodc_pkg.sv
// Constants shared by the I/O bus data channel device
// How it works
// - Answer programmed strobes only when unit and subunit select lines carry our own code.
// - First strobe only tests the skip flag; it never reads a buffer.
// - Second strobe sends data or clears flags; never decides a skip.
// - Third strobe takes data in; never skips nor sends data out.
// - Eighteen-bit data words travel over the shared two-way data bus.
// - During a priority break, drive the trap address onto address lines.
// - During a channel transfer, drive the word count address.
// - While read status is high, drive status bits onto data lines.
// - On word total overflow, stop after this transfer and interrupt.
// - Sum overflow marks the add-to-memory result as wrong.
// - A channel request asks for a transfer or memory cycle.
// - Assert memory read request when the channel wants a memory word.
// - Assert word offer request when the device sends a word inward.
// - Level zero priority request asks for the highest level service.
// - Program interrupt request asks the running program for service.
// - Skip request reports the state of the interrupt flag.
// - Channel and priority requests rise only at sync pulse time.
// - On channel grant, gate the word count address onto address lines.
// - Request only with chain enable in; requesting cuts chain enable out.
// - Return skip during first strobe when the tested flag is set.
package iodc_pkg;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 4;
  localparam int UNIT_W = 6;
  localparam int SUB_W = 2;
  // Subunit codes
  localparam logic [1:0] SUB_FLAG = 2'h0;
  localparam logic [1:0] SUB_DATA = 2'h1;
  // Control word bit positions, loaded by the third strobe on SUB_FLAG
  localparam int CTL_ENABLE = 0;
  localparam int CTL_DIR_OUT = 1;
  localparam int CTL_PRI_MODE = 2;
  // Status bit positions
  localparam int ST_FLAG = 0;
  localparam int ST_SUM_ERR = 1;
  localparam int ST_FULL = 2;
  localparam int ST_ENABLE = 3;
  localparam int ST_DIR_OUT = 4;
  localparam int ST_PRI_MODE = 5;
  // Reset values
  localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 4'h0;
  // Edge detector lanes
  localparam int EV_W = 7;
  localparam int EV_SYNC = 0;
  localparam int EV_OP1 = 1;
  localparam int EV_OP2 = 2;
  localparam int EV_OP3 = 3;
  localparam int EV_TOT = 4;
  localparam int EV_CGR = 5;
  localparam int EV_PGR = 6;
  // Channel states, Gray along idle, request, serve
  typedef enum logic [1:0] {
    IODC_IDLE = 2'b00,
    IODC_REQ = 2'b01,
    IODC_SERVE = 2'b11
  } iodc_ch_t;
endpackage : iodc_pkg

// File: logic/iodc_rise.sv
// Rising edge detector for a group of bus strobes
`timescale 1ns/100ps
`default_nettype none
module iodc_rise #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels in, one-cycle pulses out
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] prev;

  // Remember last level
  always_ff @(posedge clk)
  begin
    if (rst)
      prev <= '0;
    else
      prev <= level;
  end

  // Pulse on a low to high change
  assign rise = level & ~prev;
endmodule : iodc_rise
`default_nettype wire

// File: logic/iodc_device.sv
// Device end of the I/O bus with multi-cycle data channel
`timescale 1ns/100ps
`default_nettype none
module iodc_device #(
  parameter logic [iodc_pkg::UNIT_W-1:0] UNIT_CODE = 6'h2A, // Arbitrary value
  parameter logic [iodc_pkg::ADDR_W-1:0] TRAP_ADDR = 4'h4,
  parameter logic [iodc_pkg::ADDR_W-1:0] COUNT_ADDR = 4'h8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic io_clear,
  // Select and strobes
  input wire logic [iodc_pkg::UNIT_W-1:0] unit_select_lines,
  input wire logic subunit_select_line_low,
  input wire logic subunit_select_line_high,
  input wire logic op_strobe_first,
  input wire logic op_strobe_second,
  input wire logic op_strobe_third,
  input wire logic sync_pulse,
  input wire logic read_status_instruction,
  // Overflow notices
  input wire logic word_total_overflow,
  input wire logic sum_overflow,
  // Data bus pin
  input wire logic [iodc_pkg::DATA_W-1:0] bus_data_in,
  output logic [iodc_pkg::DATA_W-1:0] bus_data_out,
  output logic bus_data_oe,
  // Address lines
  output logic [iodc_pkg::ADDR_W-1:0] bus_addr_out,
  output logic bus_addr_oe,
  // Channel handshake
  input wire logic channel_grant,
  input wire logic channel_chain_enable_in,
  output logic channel_chain_enable_out,
  output logic channel_request_n,
  output logic memory_read_request_n,
  output logic word_offer_request_n,
  // Interrupts and skip
  input wire logic priority_grant,
  input wire logic priority_chain_enable_in,
  output logic priority_chain_enable_out,
  output logic priority_level_zero_request_n,
  output logic program_interrupt_request_n,
  output logic skip_request_n,
  // User side words
  input wire logic [iodc_pkg::DATA_W-1:0] user_in_word,
  input wire logic user_in_valid,
  output logic user_in_ready,
  output logic [iodc_pkg::DATA_W-1:0] user_out_word,
  output logic user_out_valid
);
  import iodc_pkg::*;

  logic init;
  logic selected;
  logic [SUB_W-1:0] sub;
  logic [EV_W-1:0] ev_level;
  logic [EV_W-1:0] ev;
  iodc_ch_t ch_state;
  iodc_ch_t next_ch_state;
  logic ch_enable;
  logic dir_out;
  logic pri_mode;
  logic flag;
  logic sum_error;
  logic last_word;
  logic word_full;
  logic [DATA_W-1:0] data_reg;
  logic pri_req;
  logic pri_served;
  logic ch_want;
  logic ch_end;
  logic flag_cmd;
  logic data_cmd;
  logic [DATA_W-1:0] status_vec;

  // System clear acts like reset
  assign init = rst | io_clear;

  // Own code decode
  assign selected = (unit_select_lines == UNIT_CODE);
  assign sub = {subunit_select_line_high, subunit_select_line_low};
  assign flag_cmd = selected && (sub == SUB_FLAG);
  assign data_cmd = selected && (sub == SUB_DATA);

  // Strobe edges
  assign ev_level = {priority_grant, channel_grant, word_total_overflow,
                     op_strobe_third, op_strobe_second, op_strobe_first,
                     sync_pulse};

  iodc_rise #(
    .W(EV_W)
  ) iodc_rise_inst (
    .clk(clk),
    .rst(init),
    .level(ev_level),
    .rise(ev)
  );

  // Status word, one line per bit
  always_comb
  begin
    status_vec = '0;
    status_vec[ST_FLAG] = flag;
    status_vec[ST_SUM_ERR] = sum_error;
    status_vec[ST_FULL] = word_full;
    status_vec[ST_ENABLE] = ch_enable;
    status_vec[ST_DIR_OUT] = dir_out;
    status_vec[ST_PRI_MODE] = pri_mode;
  end

  // Channel work pending in the selected direction
  assign ch_want = ch_enable && (dir_out || word_full);
  assign ch_end = (ch_state == IODC_SERVE) && !channel_grant;

  // Control word, taken in by the third strobe
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      dir_out <= 1'b0;
      pri_mode <= 1'b0;
    end
    else if (flag_cmd && ev[EV_OP3] && (ch_state == IODC_IDLE))
    begin
      dir_out <= bus_data_in[CTL_DIR_OUT];
      pri_mode <= bus_data_in[CTL_PRI_MODE];
    end
  end

  // Channel enable; a finished word total stops the channel
  always_ff @(posedge clk)
  begin
    if (init)
      ch_enable <= 1'b0;
    else if (ch_end && last_word)
      ch_enable <= 1'b0;
    else if (flag_cmd && ev[EV_OP3] && (ch_state == IODC_IDLE))
      ch_enable <= bus_data_in[CTL_ENABLE];
  end

  // Word total reached, held until this transfer ends
  always_ff @(posedge clk)
  begin
    if (init)
      last_word <= 1'b0;
    else if (ev[EV_TOT] && (ch_state != IODC_IDLE))
      last_word <= 1'b1;
    else if (ch_end)
      last_word <= 1'b0;
  end

  // Done flag; set wins over the clearing strobe
  always_ff @(posedge clk)
  begin
    if (init)
      flag <= 1'b0;
    else if (ch_end && last_word)
      flag <= 1'b1;
    else if (flag_cmd && ev[EV_OP2])
      flag <= 1'b0;
  end

  // Sum overflow notice; set wins over clear
  always_ff @(posedge clk)
  begin
    if (init)
      sum_error <= 1'b0;
    else if (sum_overflow && (ch_state == IODC_SERVE))
      sum_error <= 1'b1;
    else if (flag_cmd && ev[EV_OP2])
      sum_error <= 1'b0;
  end

  // Device data register and user handshake
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      data_reg <= DATA_RESET;
      word_full <= 1'b0;
    end
    else if (user_in_valid && !word_full && !dir_out)
    begin
      data_reg <= user_in_word;
      word_full <= 1'b1;
    end
    else if (data_cmd && ev[EV_OP3])
      data_reg <= bus_data_in;
    else if ((ch_state == IODC_SERVE) && !dir_out && ev[EV_OP2])
      word_full <= 1'b0;
    else if (data_cmd && ev[EV_OP2])
      word_full <= 1'b0;
  end

  // Ready toward the user source
  always_ff @(posedge clk)
  begin
    if (init)
      user_in_ready <= 1'b0;
    else
      user_in_ready <= !word_full && !dir_out && !user_in_valid;
  end

  // Words read from memory go to the user
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      user_out_word <= DATA_RESET;
      user_out_valid <= 1'b0;
    end
    else
    begin
      user_out_valid <= (ch_state == IODC_SERVE) && dir_out && ev[EV_OP3];
      if ((ch_state == IODC_SERVE) && dir_out && ev[EV_OP3])
        user_out_word <= bus_data_in;
    end
  end

  // Channel sequencing
  always_comb
  begin
    next_ch_state = ch_state;
    unique case (ch_state)
      IODC_IDLE:
        if (ch_want && ev[EV_SYNC] && channel_chain_enable_in)
          next_ch_state = IODC_REQ;
      IODC_REQ:
        if (ev[EV_CGR])
          next_ch_state = IODC_SERVE;
      IODC_SERVE:
        if (!channel_grant)
          next_ch_state = IODC_IDLE;
      default:
        next_ch_state = IODC_IDLE;
    endcase
  end

  // Channel state register
  always_ff @(posedge clk)
  begin
    if (init)
      ch_state <= IODC_IDLE;
    else
      ch_state <= next_ch_state;
  end

  // Channel request lines; posting cuts the chain below
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      channel_request_n <= 1'b1;
      memory_read_request_n <= 1'b1;
      word_offer_request_n <= 1'b1;
      channel_chain_enable_out <= 1'b0;
    end
    else
    begin
      channel_request_n <= !(next_ch_state == IODC_REQ);
      memory_read_request_n <= !((next_ch_state != IODC_IDLE) && dir_out);
      word_offer_request_n <= !((next_ch_state != IODC_IDLE) && !dir_out);
      channel_chain_enable_out <= channel_chain_enable_in &&
                                  (next_ch_state != IODC_REQ);
    end
  end

  // Priority request at sync time, dropped on grant
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      pri_req <= 1'b0;
      pri_served <= 1'b0;
    end
    else
    begin
      if (ev[EV_PGR])
        pri_req <= 1'b0;
      else if (flag && pri_mode && !pri_served && ev[EV_SYNC] &&
               priority_chain_enable_in)
        pri_req <= 1'b1;
      else if (!flag)
        pri_req <= 1'b0;
      if (ev[EV_PGR] && pri_req)
        pri_served <= 1'b1;
      else if (!flag)
        pri_served <= 1'b0;
    end
  end

  // Priority and program interrupt pins
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      priority_level_zero_request_n <= 1'b1;
      priority_chain_enable_out <= 1'b0;
      program_interrupt_request_n <= 1'b1;
    end
    else
    begin
      priority_level_zero_request_n <= !pri_req;
      priority_chain_enable_out <= priority_chain_enable_in && !pri_req;
      program_interrupt_request_n <= !(flag && !pri_mode);
    end
  end

  // Skip answers the first strobe only
  always_ff @(posedge clk)
  begin
    if (init)
      skip_request_n <= 1'b1;
    else
      skip_request_n <= !(flag_cmd && op_strobe_first && flag);
  end

  // Address lines: trap address on priority grant, count address on channel
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      bus_addr_out <= ADDR_RESET;
      bus_addr_oe <= 1'b0;
    end
    else if (priority_grant && pri_served)
    begin
      bus_addr_out <= TRAP_ADDR;
      bus_addr_oe <= 1'b1;
    end
    else if (ch_state == IODC_SERVE)
    begin
      bus_addr_out <= COUNT_ADDR;
      bus_addr_oe <= 1'b1;
    end
    else
    begin
      bus_addr_out <= ADDR_RESET;
      bus_addr_oe <= 1'b0;
    end
  end

  // Data bus drive: status, or data word on the second strobe
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      bus_data_out <= DATA_RESET;
      bus_data_oe <= 1'b0;
    end
    else if (read_status_instruction)
    begin
      bus_data_out <= status_vec;
      bus_data_oe <= 1'b1;
    end
    else if (op_strobe_second && (data_cmd ||
             ((ch_state == IODC_SERVE) && !dir_out)))
    begin
      bus_data_out <= data_reg;
      bus_data_oe <= 1'b1;
    end
    else
    begin
      bus_data_out <= DATA_RESET;
      bus_data_oe <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (init);

  chk_skip_cause: assert property ($fell(skip_request_n) |->
    $past(flag_cmd && op_strobe_first && flag))
    else $error("skip without first strobe and flag");

  chk_req_at_sync: assert property ($fell(channel_request_n) |->
    $past(ev[EV_SYNC] && channel_chain_enable_in))
    else $error("channel request off sync or chain");

  chk_chain_cut: assert property (!channel_request_n |->
    !channel_chain_enable_out)
    else $error("chain enable passed while requesting");

  chk_count_addr: assert property ((ch_state == IODC_REQ && ev[EV_CGR]) |=>
    ##1 (bus_addr_oe && bus_addr_out == COUNT_ADDR))
    else $error("count address missing after grant");

  chk_trap_addr: assert property ((priority_grant && pri_served) |=>
    (bus_addr_oe && bus_addr_out == TRAP_ADDR))
    else $error("trap address missing in priority break");

  chk_status_out: assert property (read_status_instruction |=>
    (bus_data_oe && bus_data_out == $past(status_vec)))
    else $error("status not driven");

  chk_third_nodrive: assert property ((op_strobe_third && !op_strobe_second &&
    !read_status_instruction) |=> !bus_data_oe)
    else $error("third strobe drove data bus");

  chk_total_stop: assert property ((ch_end && last_word) |=>
    (!ch_enable && flag) ##1 !program_interrupt_request_n || pri_mode)
    else $error("word total did not stop channel");

  chk_sum_flag: assert property ((sum_overflow && ch_state == IODC_SERVE) |=>
    sum_error)
    else $error("sum overflow not noted");

  chk_dir_req: assert property (!channel_request_n |->
    (memory_read_request_n != word_offer_request_n))
    else $error("direction request lines wrong");

  cov_in_transfer: cover property ((ch_state == IODC_SERVE && !dir_out) ##[1:50]
    bus_data_oe);
  cov_out_transfer: cover property (user_out_valid);
  cov_total_done: cover property (ch_end && last_word);
  cov_pri_break: cover property (bus_addr_oe && bus_addr_out == TRAP_ADDR);
endmodule : iodc_device
`default_nettype wire

// File: verification/iodc_host_model.sv
// Host I/O processor model facing the device end of the bus
`timescale 1ns/100ps
`default_nettype none
module iodc_host_model (
  // Clock
  input wire logic clk,
  // Selects, strobes and notices toward the device
  output logic [iodc_pkg::UNIT_W-1:0] unit_sel,
  output logic sub_lo,
  output logic sub_hi,
  output logic op1,
  output logic op2,
  output logic op3,
  output logic sync,
  output logic rd_stat,
  output logic tot_oflo,
  output logic sum_oflo,
  output logic ch_grant,
  output logic pri_grant,
  output logic [iodc_pkg::DATA_W-1:0] data_in,
  // Device answers
  input wire logic [iodc_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic [iodc_pkg::ADDR_W-1:0] addr,
  input wire logic ch_req_n,
  input wire logic mem_req_n,
  input wire logic offer_n,
  input wire logic chain_out,
  input wire logic pri_req_n,
  input wire logic skip_n
);
  import iodc_pkg::*;
  int cnt = 0;
  int delay = 1;
  int n_served = 0;
  int n_prio = 0;
  int req_cnt, prio_cnt;
  logic oflo = 1'b0;
  logic bad_sum = 1'b0;
  logic drv = 1'b0;
  logic rd_seen, cut_seen, skip_seen, oe_seen;
  logic [DATA_W-1:0] word = '0;
  logic [DATA_W-1:0] out_word = '0;
  logic [DATA_W-1:0] got;
  logic [ADDR_W-1:0] got_addr, got_trap;
  // Released bus shows the inverse of the last value driven
  assign data_in = data_oe ? data_out : (drv ? word : ~word);
  // Sync pulse of 250 ns in every microsecond
  assign sync = cnt < 10;
  always @(negedge clk)
    cnt <= (cnt == 39) ? 0 : cnt + 1;
  // Channel service: grant, word count address, one strobe, notices
  initial
  begin
    {unit_sel, sub_lo, sub_hi, op1, op2, op3, rd_stat} = '0;
    {tot_oflo, sum_oflo, ch_grant, pri_grant} = '0;
    forever
    begin
      @(negedge clk);
      if (!ch_req_n)
      begin
        req_cnt = cnt;
        rd_seen = !mem_req_n;
        cut_seen = !chain_out;
        repeat (delay) @(negedge clk);
        ch_grant = 1'b1;
        repeat (4) @(negedge clk);
        got_addr = addr;
        word = out_word;
        op2 = !offer_n;
        op3 = offer_n;
        drv = offer_n;
        tot_oflo = oflo;
        sum_oflo = bad_sum;
        @(negedge clk);
        tot_oflo = 1'b0;
        repeat (8) @(negedge clk);
        got = data_out;
        {op2, op3, drv, sum_oflo} = '0;
        @(negedge clk);
        ch_grant = 1'b0;
        n_served++;
      end
    end
  end
  // Priority break: grant, then take the trap address
  initial
  forever
  begin
    @(negedge clk);
    if (!pri_req_n)
    begin
      prio_cnt = cnt;
      repeat (delay) @(negedge clk);
      pri_grant = 1'b1;
      repeat (4) @(negedge clk);
      got_trap = addr;
      pri_grant = 1'b0;
      n_prio++;
    end
  end
  // Programmed transfer: op 0 reads status, 1 to 3 raise that strobe
  task automatic pio(input logic [UNIT_W-1:0] u, input logic [1:0] s, input int op,
      input logic [DATA_W-1:0] d);
    @(negedge clk);
    unit_sel = u;
    {sub_hi, sub_lo} = s;
    word = d;
    drv = (op == 3);
    rd_stat = (op == 0);
    op1 = (op == 1);
    op2 = (op == 2);
    op3 = (op == 3);
    repeat (9) @(negedge clk);
    skip_seen = !skip_n;
    oe_seen = data_oe;
    got = data_out;
    {rd_stat, op1, op2, op3, drv, unit_sel} = '0;
    @(negedge clk);
  endtask : pio
endmodule : iodc_host_model
`default_nettype wire

// File: verification/iodc_device_test.sv
// Self-checking bench for the I/O bus data channel device
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module iodc_device_test;
  import iodc_pkg::*;
  localparam logic [UNIT_W-1:0] UNIT = 6'h2A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic io_clear = 1'b0;
  logic [DATA_W-1:0] in_word = '0;
  logic in_valid = 1'b0;
  logic chain_en = 1'b1;
  logic seen_aoe = 1'b0;
  logic seen_cut = 1'b0;
  int fails = 0;
  int n_compared = 0;
  logic [UNIT_W-1:0] unit_sel;
  logic [DATA_W-1:0] data_in, data_out, out_word, seen_out;
  logic [ADDR_W-1:0] addr;
  logic sub_lo, sub_hi, op1, op2, op3, sync, rd_stat, tot_oflo, sum_oflo;
  logic ch_grant, pri_grant, data_oe, addr_oe, ch_req_n, mem_req_n, offer_n;
  logic chain_out, pri_out, pri_req_n, prog_n, skip_n, ready, out_valid;
  iodc_device #(.UNIT_CODE(UNIT)) iodc_device_inst (
    .clk(clk), .rst(rst), .io_clear(io_clear),
    .unit_select_lines(unit_sel), .subunit_select_line_low(sub_lo),
    .subunit_select_line_high(sub_hi), .op_strobe_first(op1),
    .op_strobe_second(op2), .op_strobe_third(op3), .sync_pulse(sync),
    .read_status_instruction(rd_stat), .word_total_overflow(tot_oflo),
    .sum_overflow(sum_oflo), .bus_data_in(data_in), .bus_data_out(data_out),
    .bus_data_oe(data_oe), .bus_addr_out(addr), .bus_addr_oe(addr_oe),
    .channel_grant(ch_grant), .channel_chain_enable_in(chain_en),
    .channel_chain_enable_out(chain_out), .channel_request_n(ch_req_n),
    .memory_read_request_n(mem_req_n), .word_offer_request_n(offer_n),
    .priority_grant(pri_grant), .priority_chain_enable_in(chain_en),
    .priority_chain_enable_out(pri_out), .priority_level_zero_request_n(pri_req_n),
    .program_interrupt_request_n(prog_n), .skip_request_n(skip_n),
    .user_in_word(in_word), .user_in_valid(in_valid), .user_in_ready(ready),
    .user_out_word(out_word), .user_out_valid(out_valid));
  iodc_host_model host_inst (
    .clk(clk), .unit_sel(unit_sel), .sub_lo(sub_lo), .sub_hi(sub_hi), .op1(op1),
    .op2(op2), .op3(op3), .sync(sync), .rd_stat(rd_stat), .tot_oflo(tot_oflo),
    .sum_oflo(sum_oflo), .ch_grant(ch_grant), .pri_grant(pri_grant),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .addr(addr),
    .ch_req_n(ch_req_n), .mem_req_n(mem_req_n), .offer_n(offer_n),
    .chain_out(chain_out), .pri_req_n(pri_req_n), .skip_n(skip_n));
  // Clock of 25 ns
  initial
  forever
    #12.5 clk = ~clk;
  // Wait for a channel transfer to end, catching the user output pulse
  task automatic wait_served(input int n);
    seen_aoe = 1'b0;
    for (int i = 0; i < 400 && host_inst.n_served < n; i++)
    begin
      @(negedge clk);
      if (out_valid === 1'b1)
        seen_out = out_word;
      if (addr_oe === 1'b1)
        seen_aoe = 1'b1;
    end
    `CHECK(host_inst.n_served, n)
    `CHECK(seen_aoe, 1'b1)
  endtask : wait_served
  // Foreign unit code ignored, status readout, system clear
  task automatic t_select;
    host_inst.pio(6'h15, 2'h0, 3, 18'h00004);
    host_inst.pio(UNIT, 2'h0, 0, '0);
    `CHECK(host_inst.got, 18'h00000)
    `CHECK(host_inst.oe_seen, 1'b1)
    host_inst.pio(UNIT, 2'h0, 3, 18'h00004);
    host_inst.pio(UNIT, 2'h0, 0, '0);
    `CHECK(host_inst.got, 18'h1 << ST_PRI_MODE)
    io_clear = 1'b1;
    repeat (2) @(negedge clk);
    io_clear = 1'b0;
    host_inst.pio(UNIT, 2'h0, 0, '0);
    `CHECK(host_inst.got, 18'h00000)
    $display("test select done");
  endtask : t_select
  // Data register loaded by third strobe, read back by second
  task automatic t_data;
    host_inst.pio(UNIT, 2'h1, 3, 18'h2A5C3);
    `CHECK(host_inst.oe_seen, 1'b0)
    host_inst.pio(UNIT, 2'h1, 2, '0);
    `CHECK(host_inst.oe_seen, 1'b1)
    `CHECK(host_inst.got, 18'h2A5C3)
    $display("test data done");
  endtask : t_data
  // Inward channel word with both overflow notices, then skip and clear
  task automatic t_chan_in;
    host_inst.oflo = 1'b1;
    host_inst.bad_sum = 1'b1;
    host_inst.pio(UNIT, 2'h0, 3, 18'h00001);
    chain_en = 1'b0;
    for (int i = 0; i < 20 && ready !== 1'b1; i++)
      @(negedge clk);
    `CHECK(ready, 1'b1)
    in_word = 18'h15A5A;
    in_valid = 1'b1;
    @(negedge clk);
    in_valid = 1'b0;
    `CHECK(ready, 1'b0)
    // Chain enable held off across a sync pulse: no request may go out
    repeat (50) @(negedge clk);
    `CHECK(ch_req_n, 1'b1)
    `CHECK(chain_out, 1'b0)
    chain_en = 1'b1;
    wait_served(1);
    `CHECK(host_inst.rd_seen, 1'b0)
    `CHECK(host_inst.cut_seen, 1'b1)
    `CHECK(host_inst.got_addr, 4'h8)
    `CHECK(host_inst.got, 18'h15A5A)
    `CHECK(host_inst.req_cnt < 10, 1'b1)
    repeat (2) @(negedge clk);
    `CHECK(prog_n, 1'b0)
    host_inst.pio(UNIT, 2'h0, 0, '0);
    `CHECK(host_inst.got, 18'h00003)
    host_inst.pio(UNIT, 2'h0, 1, '0);
    `CHECK(host_inst.skip_seen, 1'b1)
    host_inst.pio(UNIT, 2'h0, 2, '0);
    host_inst.pio(UNIT, 2'h0, 1, '0);
    `CHECK(host_inst.skip_seen, 1'b0)
    host_inst.bad_sum = 1'b0;
    $display("test channel in done");
  endtask : t_chan_in
  // Outward channel word with a slow grant
  task automatic t_chan_out;
    host_inst.delay = 20;
    host_inst.out_word = 18'h3C0F1;
    host_inst.pio(UNIT, 2'h0, 3, 18'h00003);
    wait_served(2);
    `CHECK(host_inst.rd_seen, 1'b1)
    `CHECK(seen_out, 18'h3C0F1)
    host_inst.pio(UNIT, 2'h0, 0, '0);
    `CHECK(host_inst.got, 18'h00011)
    $display("test channel out done");
  endtask : t_chan_out
  // Priority request from the raised flag, trap address on grant
  task automatic t_prio;
    host_inst.delay = 1;
    host_inst.pio(UNIT, 2'h0, 3, 18'h00004);
    for (int i = 0; i < 200 && host_inst.n_prio < 1; i++)
    begin
      @(negedge clk);
      if (pri_req_n === 1'b0)
        seen_cut = !pri_out;
    end
    `CHECK(host_inst.n_prio, 1)
    `CHECK(seen_cut, 1'b1)
    `CHECK(pri_out, 1'b1)
    `CHECK(host_inst.got_trap, 4'h4)
    `CHECK(host_inst.prio_cnt < 10, 1'b1)
    `CHECK(prog_n, 1'b1)
    host_inst.pio(UNIT, 2'h0, 2, '0);
    $display("test priority done");
  endtask : t_prio
  // Counts and verdict
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  // Main sequence
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_select;
    t_data;
    t_chan_in;
    t_chan_out;
    t_prio;
    final_report;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #500000;
    fails++;
    final_report;
  end
endmodule : iodc_device_test
`default_nettype wire
